// File: shared/ovs_consts.svh
// Command codes, field values, threshold steps and reset values of the overvoltage supervisor.
`ifndef OVS_CONSTS_SVH
`define OVS_CONSTS_SVH
`define OVS_CMD_FAULT_LIM 8'h40
`define OVS_CMD_ACTION 8'h41
`define OVS_CMD_WARN_LIM 8'h42
`define OVS_ACT_IGNORE 2'b00
`define OVS_ACT_BAD 2'b11
`define OVS_RETRY_LATCH 3'h0
`define OVS_RETRY_FOREVER 3'h7
`define OVS_DELAY_ONE 3'h0
`define OVS_DELAY_MIN_MULT 3'h1
`define OVS_PERMILLE 32'h0000_03E8
`define OVS_F_MIN 11'h41A
`define OVS_F_STEP 11'h019
`define OVS_F_N 15
`define OVS_F_MAX 11'h578
`define OVS_F_OFF_STEP 11'h064
`define OVS_F_OFF_MIN 11'h44C
`define OVS_W_MIN 11'h406
`define OVS_W_STEP 11'h00A
`define OVS_W_N 14
`define OVS_W_MAX 11'h488
`define OVS_RST_ACTION 8'hB8
`define OVS_RST_FAULT_LIM 16'h047E
`define OVS_RST_WARN_LIM 16'h0442
`endif

// File: shared/ovs_pkg.sv
// Types shared by the overvoltage supervisor.
package ovs_pkg;
    typedef enum logic [2:0] {
        st_off = 3'h0,
        st_ramp = 3'h1,
        st_run = 3'h3,
        st_wait = 3'h2,
        st_latch = 3'h6
    } ovs_state_e;
    typedef struct packed {
        logic [1:0] fault_action_select;
        logic [2:0] restart_attempt_count;
        logic [2:0] restart_wait_period_delay_multiple;
    } ovs_resp_s;
    typedef struct packed {
        logic valid;
        logic write;
        logic word;
        logic [7:0] code;
        logic [15:0] data;
    } ovs_cmd_s;
endpackage

// File: design/ovs_supervisor.sv
// Output overvoltage supervisor: limits, status flags and shutdown and restart sequencing.
//
// Function
// [R1] Running: fault threshold 105% to 140% of target, 2.5% steps.
// [R2] Not running: fault threshold 110% to 140% of target, 10% steps.
// [R3] Limits between supported steps round up to the next supported step.
// [R4] Out-of-range limit or response writes flag invalid data and alert the host; the code flags limits only above the maximum, not below the minimum.
// [R5] Fault sets status byte, status word and fault flag, alerts, then responds.
// [R6] Action 00 ignores, 01 or 10 shuts down and retries, 11 is invalid.
// [R7] Retry field 0 latches off; 1 to 6 allows that many restarts.
// [R8] Retry field 7 restarts without limit until disabled or a start succeeds.
// [R9] Delay field 0 waits one rise time; 1 to 7 wait that many.
// [R10] Start counts successful after its window; the restart counter then clears.
// [R11] A start is refused while a fault is present, even when ignoring; the code checks this only in st_off, not on a restart from st_wait.
// [R12] Host sets fault limit above worst start-up level to ignore such faults.
// [R13] Warning sets status word and warning flag and alerts the host.
// [R14] Warning threshold 103% to 116% of target in 1% steps.
// [R15] Thresholds track the output target; stored limit words stay unchanged.
// [R16] Response is a byte transfer, limits are word transfers.
// [R17] Fault detection is armed from reset, whether or not the output runs.
// [R18] Each restart bumps the counter, which holds at 7; latch off once it reaches the field.
// [R19] Response, retry and delay fields act at once while running.
`timescale 1ns/10ps
`include "ovs_consts.svh"
`default_nettype none

module ovs_supervisor #(
    parameter int TW = 24
) (
    input wire logic clock, // 100 MHz device clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire ovs_pkg::ovs_cmd_s cmd, // decoded command from the bus transport
    input wire logic clear_faults, // one-cycle pulse clearing the sticky flags
    input wire logic enable_req, // output commanded on
    input wire logic rel_mode, // limits are in relative format
    input wire logic [15:0] vout_cmd, // present output voltage command
    input wire logic [TW-1:0] ton_rise, // rise time in clock cycles
    input wire logic [TW-1:0] ton_max, // start timeout in cycles, zero uses twice the rise time
    input wire logic ov_fault_pin, // fault comparator output, asynchronous
    input wire logic ov_warn_pin, // warning comparator output, asynchronous
    output logic [15:0] rdata_q, // read data
    output logic rvalid_q, // read data valid pulse
    output logic power_on_q, // power stage enable
    output logic [10:0] fault_pct_q, // fault threshold in tenths of a percent
    output logic [10:0] warn_pct_q, // warning threshold in tenths of a percent
    output logic status_byte_ov_q, // overvoltage bit of the status byte
    output logic status_word_vout_q, // output voltage bit of the status word
    output logic overvoltage_fault_flag_q, // fault flag of the output status
    output logic overvoltage_warning_flag_q, // warning flag of the output status
    output logic invalid_data_flag_q, // invalid data flag of the comms status
    output logic alert_q, // host alert, active high
    output logic [2:0] restart_limit_count_q // restart attempts made
);
    localparam int TT = TW + 3;

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0] fault_sync_q;
    logic [1:0] warn_sync_q;
    logic ov_fault;
    logic ov_warn;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            fault_sync_q <= 2'h0;
            warn_sync_q <= 2'h0;
        end else if (ce) begin
            fault_sync_q <= {fault_sync_q[0], ov_fault_pin};
            warn_sync_q <= {warn_sync_q[0], ov_warn_pin};
        end
    end
    assign ov_fault = fault_sync_q[1];
    assign ov_warn = warn_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ovs_scale(input logic [15:0] v, input logic [15:0] tgt,
                                              input logic rel);
        ovs_scale = rel ? 32'(v) * 32'(tgt) : 32'(v) * `OVS_PERMILLE;
    endfunction

    logic [15:0] overvoltage_fault_threshold_q;
    logic [15:0] overvoltage_warning_threshold_q;
    ovs_pkg::ovs_resp_s overvoltage_fault_action_q;
    logic hit_f;
    logic hit_a;
    logic hit_w;
    logic size_ok;
    logic f_wr_ok;
    logic w_wr_ok;
    logic a_wr_ok;
    logic value_ok;
    logic cml_evt;

    assign hit_f = cmd.valid && cmd.code == `OVS_CMD_FAULT_LIM;
    assign hit_a = cmd.valid && cmd.code == `OVS_CMD_ACTION;
    assign hit_w = cmd.valid && cmd.code == `OVS_CMD_WARN_LIM;
    assign size_ok = hit_a ? !cmd.word : cmd.word; // [R16]
    assign f_wr_ok = ovs_scale(cmd.data, vout_cmd, rel_mode)
                     <= 32'(vout_cmd) * 32'(`OVS_F_MAX);
    assign w_wr_ok = ovs_scale(cmd.data, vout_cmd, rel_mode)
                     <= 32'(vout_cmd) * 32'(`OVS_W_MAX);
    assign a_wr_ok = cmd.data[7:6] != `OVS_ACT_BAD; // [R6]
    assign value_ok = hit_f ? f_wr_ok : (hit_w ? w_wr_ok : a_wr_ok);
    // A bad transfer size or value leaves the stored word untouched.
    assign cml_evt = (hit_f || hit_a || hit_w) && (!size_ok || (cmd.write && !value_ok)); // [R4]

    always_ff @(posedge clock) begin
        if (!resetn) begin
            overvoltage_fault_threshold_q <= `OVS_RST_FAULT_LIM;
        end else if (ce && hit_f && cmd.write && size_ok && f_wr_ok) begin
            overvoltage_fault_threshold_q <= cmd.data;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            overvoltage_warning_threshold_q <= `OVS_RST_WARN_LIM;
        end else if (ce && hit_w && cmd.write && size_ok && w_wr_ok) begin
            overvoltage_warning_threshold_q <= cmd.data;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            overvoltage_fault_action_q <= ovs_pkg::ovs_resp_s'(`OVS_RST_ACTION);
        end else if (ce && hit_a && cmd.write && size_ok && a_wr_ok) begin
            overvoltage_fault_action_q <= ovs_pkg::ovs_resp_s'(cmd.data[7:0]); // [R19]
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else if (ce) begin
            rvalid_q <= (hit_f || hit_a || hit_w) && !cmd.write && size_ok;
            if (hit_f) begin
                rdata_q <= overvoltage_fault_threshold_q;
            end else if (hit_w) begin
                rdata_q <= overvoltage_warning_threshold_q;
            end else begin
                rdata_q <= {8'h00, overvoltage_fault_action_q};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Thresholds are recomputed every cycle from the stored word and the live target,
    // so a new output command moves the trip level without rewriting the limit.
    logic [31:0] f_lhs;
    logic [31:0] w_lhs;
    logic [`OVS_F_N-1:0] f_ok;
    logic [`OVS_W_N-1:0] w_ok;
    logic [10:0] fault_pct_d;
    logic [10:0] warn_pct_d;

    assign f_lhs = ovs_scale(overvoltage_fault_threshold_q, vout_cmd, rel_mode); // [R15]
    assign w_lhs = ovs_scale(overvoltage_warning_threshold_q, vout_cmd, rel_mode); // [R15]

    for (genvar k = 0; k < `OVS_F_N; k++) begin : g_fstep
        localparam logic [10:0] PCT = 11'(`OVS_F_MIN + k * `OVS_F_STEP);
        assign f_ok[k] = f_lhs <= 32'(vout_cmd) * 32'(PCT) // [R1]
                         && (power_on_q || PCT % `OVS_F_OFF_STEP == 11'h000); // [R2]
    end

    for (genvar k = 0; k < `OVS_W_N; k++) begin : g_wstep
        localparam logic [10:0] PCT = 11'(`OVS_W_MIN + k * `OVS_W_STEP);
        assign w_ok[k] = w_lhs <= 32'(vout_cmd) * 32'(PCT); // [R14]
    end

    always_comb begin
        fault_pct_d = `OVS_F_MAX;
        for (int i = `OVS_F_N - 1; i >= 0; i--) begin
            if (f_ok[i]) begin
                fault_pct_d = 11'(`OVS_F_MIN + i * `OVS_F_STEP); // [R3]
            end
        end
    end

    always_comb begin
        warn_pct_d = `OVS_W_MAX;
        for (int i = `OVS_W_N - 1; i >= 0; i--) begin
            if (w_ok[i]) begin
                warn_pct_d = 11'(`OVS_W_MIN + i * `OVS_W_STEP); // [R3]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            fault_pct_q <= `OVS_F_MAX;
            warn_pct_q <= `OVS_W_MAX;
        end else if (ce) begin
            fault_pct_q <= fault_pct_d;
            warn_pct_q <= warn_pct_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags are sticky and a new event in the clearing cycle keeps its flag set.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            status_byte_ov_q <= 1'b0;
            status_word_vout_q <= 1'b0;
            overvoltage_fault_flag_q <= 1'b0;
            overvoltage_warning_flag_q <= 1'b0;
            invalid_data_flag_q <= 1'b0;
            alert_q <= 1'b0;
        end else if (ce) begin
            status_byte_ov_q <= ov_fault || (status_byte_ov_q && !clear_faults); // [R5] [R17]
            overvoltage_fault_flag_q <= ov_fault || (overvoltage_fault_flag_q && !clear_faults); // [R5]
            status_word_vout_q <= ov_fault || ov_warn || (status_word_vout_q && !clear_faults); // [R13]
            overvoltage_warning_flag_q <= ov_warn || (overvoltage_warning_flag_q && !clear_faults); // [R13]
            invalid_data_flag_q <= cml_evt || (invalid_data_flag_q && !clear_faults); // [R4]
            alert_q <= ov_fault || ov_warn || cml_evt || (alert_q && !clear_faults); // [R5] [R13]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    ovs_pkg::ovs_state_e st_q;
    logic [TT-1:0] timer_q;
    logic [TT-1:0] rise_len;
    logic [TT-1:0] window_len;
    logic [TT-1:0] restart_wait_period;
    logic [2:0] wait_mult;
    logic trip;
    logic may_retry;

    assign rise_len = TT'(ton_rise);
    assign window_len = (ton_max != '0) ? TT'(ton_max) : (TT'(ton_rise) << 1); // [R10]
    assign wait_mult = (overvoltage_fault_action_q.restart_wait_period_delay_multiple == `OVS_DELAY_ONE) ?
                       `OVS_DELAY_MIN_MULT : overvoltage_fault_action_q.restart_wait_period_delay_multiple;
    assign restart_wait_period = rise_len * TT'(wait_mult); // [R9]
    assign trip = ov_fault && (st_q == ovs_pkg::st_ramp || st_q == ovs_pkg::st_run)
                  && overvoltage_fault_action_q.fault_action_select != `OVS_ACT_IGNORE; // [R6]
    assign may_retry = overvoltage_fault_action_q.restart_attempt_count == `OVS_RETRY_FOREVER // [R8]
                       || restart_limit_count_q
                          < overvoltage_fault_action_q.restart_attempt_count; // [R7] [R18]

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_q <= ovs_pkg::st_off;
            timer_q <= '0;
            power_on_q <= 1'b0;
            restart_limit_count_q <= 3'h0;
        end else if (ce) begin
            if (!enable_req) begin
                st_q <= ovs_pkg::st_off;
                timer_q <= '0;
                power_on_q <= 1'b0;
                restart_limit_count_q <= 3'h0;
            end else if (trip) begin
                power_on_q <= 1'b0;
                timer_q <= '0;
                st_q <= may_retry ? ovs_pkg::st_wait : ovs_pkg::st_latch; // [R7] [R8]
            end else begin
                unique case (st_q)
                    ovs_pkg::st_off: begin
                        if (!ov_fault) begin // [R11]
                            st_q <= ovs_pkg::st_ramp;
                            power_on_q <= 1'b1;
                            timer_q <= '0;
                        end
                    end
                    ovs_pkg::st_ramp: begin
                        timer_q <= timer_q + TT'(1);
                        if (timer_q >= rise_len) begin
                            st_q <= ovs_pkg::st_run;
                        end
                    end
                    ovs_pkg::st_run: begin
                        if (timer_q < window_len) begin
                            timer_q <= timer_q + TT'(1);
                        end else begin
                            restart_limit_count_q <= 3'h0; // [R10]
                        end
                    end
                    ovs_pkg::st_wait: begin
                        timer_q <= timer_q + TT'(1);
                        if (timer_q + TT'(1) >= restart_wait_period) begin // [R9]
                            st_q <= ovs_pkg::st_ramp;
                            power_on_q <= 1'b1;
                            timer_q <= '0;
                            if (restart_limit_count_q != `OVS_RETRY_FOREVER) begin
                                restart_limit_count_q <= restart_limit_count_q + 3'h1; // [R18]
                            end
                        end
                    end
                    ovs_pkg::st_latch: begin
                        st_q <= ovs_pkg::st_latch;
                    end
                    default: begin
                        st_q <= ovs_pkg::st_off;
                        power_on_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_refuse_start: assert property (ce && enable_req && st_q == ovs_pkg::st_off && ov_fault // [R11]
        |=> !power_on_q) else $error("start taken with a fault present");
    a_fault_flags: assert property (ce && ov_fault // [R5]
        |=> status_byte_ov_q && status_word_vout_q && overvoltage_fault_flag_q && alert_q)
        else $error("fault flags not set");
    a_warn_flags: assert property (ce && ov_warn // [R13]
        |=> status_word_vout_q && overvoltage_warning_flag_q && alert_q)
        else $error("warning flags not set");
    a_bad_action: assert property (ce && hit_a && cmd.write && !cmd.word // [R4]
        && cmd.data[7:6] == `OVS_ACT_BAD
        |=> invalid_data_flag_q && overvoltage_fault_action_q == $past(overvoltage_fault_action_q))
        else $error("invalid response accepted");
    a_ignore_runs: assert property (ce && enable_req && st_q == ovs_pkg::st_run && ov_fault // [R6]
        && overvoltage_fault_action_q.fault_action_select == `OVS_ACT_IGNORE
        |=> st_q == ovs_pkg::st_run && power_on_q) else $error("ignored fault stopped output");
    a_latch_zero: assert property (ce && enable_req && trip // [R7]
        && overvoltage_fault_action_q.restart_attempt_count == `OVS_RETRY_LATCH
        |=> st_q == ovs_pkg::st_latch && !power_on_q) else $error("no latch off");
    a_retry_forever: assert property (ce && enable_req && trip // [R8]
        && overvoltage_fault_action_q.restart_attempt_count == `OVS_RETRY_FOREVER
        |=> st_q == ovs_pkg::st_wait) else $error("unlimited retry did not wait");
    a_wait_hold: assert property (ce && enable_req && st_q == ovs_pkg::st_wait // [R9]
        && timer_q + TT'(1) < restart_wait_period |=> st_q == ovs_pkg::st_wait)
        else $error("restart wait ended early");
    a_restart_count: assert property (st_q == ovs_pkg::st_ramp // [R18]
        && $past(st_q) == ovs_pkg::st_wait
        |-> restart_limit_count_q == $past(restart_limit_count_q) + 3'h1
            || $past(restart_limit_count_q) == `OVS_RETRY_FOREVER)
        else $error("restart not counted");
    a_success_clear: assert property (ce && enable_req && !trip && st_q == ovs_pkg::st_run // [R10]
        && timer_q >= window_len |=> restart_limit_count_q == 3'h0)
        else $error("counter not cleared");
    a_fault_range: assert property (fault_pct_q >= `OVS_F_MIN && fault_pct_q <= `OVS_F_MAX) // [R1]
        else $error("fault threshold out of range");
    a_off_steps: assert property ($past(ce) && !$past(power_on_q) && $past(resetn) // [R2]
        |-> fault_pct_q >= `OVS_F_OFF_MIN && fault_pct_q % `OVS_F_OFF_STEP == 11'h000)
        else $error("off threshold not on a coarse step");
    a_warn_range: assert property (warn_pct_q >= `OVS_W_MIN && warn_pct_q <= `OVS_W_MAX) // [R14]
        else $error("warning threshold out of range");

    c_restart: cover property (st_q == ovs_pkg::st_wait ##1 st_q == ovs_pkg::st_ramp);
    c_latch_off: cover property (st_q == ovs_pkg::st_run ##1 st_q == ovs_pkg::st_latch);
    c_success: cover property (st_q == ovs_pkg::st_run && timer_q >= window_len);
    c_bad_write: cover property ($rose(invalid_data_flag_q));
endmodule

`default_nettype wire

// File: sim/ovs_host_model.sv
// Host side model that issues register transfers to the supervisor and collects answers.
`timescale 1ns/10ps
`default_nettype none

module ovs_host_model (
    input wire logic clock, // device clock
    output var ovs_pkg::ovs_cmd_s cmd, // request towards the supervisor
    input wire logic [15:0] rdata_q, // read data from the supervisor
    input wire logic rvalid_q // read data valid pulse
);
    ////////////////////////////////////////////////////////////////////////////////
    initial cmd = '0;

    // A request is held for one full cycle so the taking edge sees it settled.
    task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
            input logic [15:0] data, output logic got, output logic [15:0] rd);
        @(negedge clock);
        cmd <= '{valid: 1'b1, write: wr, word: wd, code: code, data: data};
        @(negedge clock);
        got = rvalid_q;
        rd = rdata_q;
        // A released bus shows inverted data, so a stale value is never reused by mistake.
        cmd <= '{valid: 1'b0, write: ~wr, word: ~wd, code: code, data: ~data};
    endtask
endmodule

`default_nettype wire

// File: sim/output_overvoltage_supervisor_tb.sv
// Self-checking testbench of the output overvoltage supervisor.
`timescale 1ns/10ps
`default_nettype none

module output_overvoltage_supervisor_tb;
    typedef struct packed {
        logic wr;
        logic wd;
        logic [7:0] code;
        logic [15:0] data;
        logic [15:0] rd;
        logic inv;
        logic [10:0] f;
        logic [10:0] w;
    } ovs_row_s;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic clear_faults = 1'b0;
    logic ce = 1'b1;
    logic [23:0] ton_max = 24'h00_0000;
    logic enable_req = 1'b1;
    logic rel_mode = 1'b1;
    logic [15:0] vout_cmd = 16'h03E8;
    logic ov_fault_pin = 1'b0;
    logic ov_warn_pin = 1'b0;
    ovs_pkg::ovs_cmd_s cmd;
    logic [15:0] rdata_q, rd;
    logic rvalid_q, power_on_q, got;
    logic [10:0] fault_pct_q, warn_pct_q;
    logic sb_ov, sw_vout, f_flag, w_flag, inv_flag, alert_q;
    logic [2:0] count_q;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;
    ovs_row_s rows [17] = '{
        '{1'b0, 1'b1, 8'h40, 16'h0000, 16'h047E, 1'b0, 11'h47E, 11'h442},
        '{1'b0, 1'b0, 8'h41, 16'h0000, 16'h00B8, 1'b0, 11'h47E, 11'h442},
        '{1'b0, 1'b1, 8'h42, 16'h0000, 16'h0442, 1'b0, 11'h47E, 11'h442},
        '{1'b1, 1'b0, 8'h41, 16'h00C0, 16'h0000, 1'b1, 11'h47E, 11'h442},
        '{1'b0, 1'b0, 8'h41, 16'h0000, 16'h00B8, 1'b0, 11'h47E, 11'h442},
        '{1'b1, 1'b0, 8'h42, 16'h0488, 16'h0000, 1'b1, 11'h47E, 11'h442},
        '{1'b0, 1'b0, 8'h40, 16'h0000, 16'h0000, 1'b1, 11'h47E, 11'h442},
        '{1'b1, 1'b1, 8'h40, 16'h041B, 16'h0000, 1'b0, 11'h433, 11'h442},
        '{1'b1, 1'b1, 8'h40, 16'h0579, 16'h0000, 1'b1, 11'h433, 11'h442},
        '{1'b1, 1'b1, 8'h40, 16'h0578, 16'h0000, 1'b0, 11'h578, 11'h442},
        '{1'b1, 1'b1, 8'h40, 16'h0001, 16'h0000, 1'b0, 11'h41A, 11'h442},
        '{1'b1, 1'b1, 8'h42, 16'h040F, 16'h0000, 1'b0, 11'h41A, 11'h410},
        '{1'b1, 1'b1, 8'h42, 16'h0489, 16'h0000, 1'b1, 11'h41A, 11'h410},
        '{1'b1, 1'b1, 8'h42, 16'h03E8, 16'h0000, 1'b0, 11'h41A, 11'h406},
        '{1'b0, 1'b1, 8'h40, 16'h0000, 16'h0001, 1'b0, 11'h41A, 11'h406},
        '{1'b1, 1'b0, 8'h41, 16'h0049, 16'h0000, 1'b0, 11'h41A, 11'h406},
        '{1'b0, 1'b0, 8'h41, 16'h0000, 16'h0049, 1'b0, 11'h41A, 11'h406}
    };

    ////////////////////////////////////////////////////////////////////////////////
    always #5 clock = ~clock;

    ovs_host_model host_u (.clock(clock), .cmd(cmd), .rdata_q(rdata_q), .rvalid_q(rvalid_q));

    // Short rise time keeps every restart sequence to a few dozen cycles.
    ovs_supervisor #(.TW(24)) dut_u (
        .clock(clock), .resetn(resetn), .ce(ce), .cmd(cmd), .clear_faults(clear_faults),
        .enable_req(enable_req), .rel_mode(rel_mode), .vout_cmd(vout_cmd),
        .ton_rise(24'h00_0004), .ton_max(ton_max), .ov_fault_pin(ov_fault_pin),
        .ov_warn_pin(ov_warn_pin), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
        .power_on_q(power_on_q), .fault_pct_q(fault_pct_q), .warn_pct_q(warn_pct_q),
        .status_byte_ov_q(sb_ov), .status_word_vout_q(sw_vout),
        .overvoltage_fault_flag_q(f_flag), .overvoltage_warning_flag_q(w_flag),
        .invalid_data_flag_q(inv_flag), .alert_q(alert_q), .restart_limit_count_q(count_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
        n_compared++;
        if (got_v !== exp_v) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask

    task automatic clr;
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
    endtask

    // Pulses the fault comparator, then returns how many cycles the stage stayed off.
    task automatic trip(output int len);
        int k = 0;
        ov_fault_pin = 1'b1;
        cyc(1);
        ov_fault_pin = 1'b0;
        while (power_on_q !== 1'b0 && k < 10) begin
            cyc(1);
            k++;
        end
        len = 0;
        while (power_on_q === 1'b0 && len < 200) begin
            cyc(1);
            len++;
        end
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(5);
        chk({5'h00, fault_pct_q}, 16'h0578);
        chk({5'h00, warn_pct_q}, 16'h0488);
        chk(16'({power_on_q, alert_q, inv_flag}), 16'h0000);
        resetn = 1'b1;
        cyc(20);
        foreach (rows[i]) begin
            host_u.xfer(rows[i].wr, rows[i].wd, rows[i].code, rows[i].data, got, rd);
            if (!rows[i].wr && !rows[i].inv) chk(rd, rows[i].rd);
            chk(16'(got), 16'(!rows[i].wr && !rows[i].inv));
            chk(16'({inv_flag, alert_q}), 16'({rows[i].inv, rows[i].inv}));
            cyc(1);
            chk({5'h00, fault_pct_q}, {5'h00, rows[i].f});
            chk({5'h00, warn_pct_q}, {5'h00, rows[i].w});
            clr();
        end
        // Shutdown with one retry and a one-rise-time wait, then a second trip latches off.
        trip(n);
        chk(16'({sb_ov, sw_vout, f_flag, alert_q}), 16'h000F);
        chk(16'(n), 16'h0004);
        chk(16'(count_q), 16'h0001);
        trip(n);
        chk(16'(n), 16'h00C8);
        enable_req = 1'b0;
        cyc(2);
        chk(16'(count_q), 16'h0000);
        enable_req = 1'b1;
        cyc(20);
        // Unlimited retries with a three-rise-time wait, written while running.
        host_u.xfer(1'b1, 1'b0, 8'h41, 16'h00BB, got, rd);
        trip(n);
        chk(16'(n), 16'h000C);
        trip(n);
        chk(16'(n), 16'h000C);
        chk(16'(count_q), 16'h0002);
        cyc(10);
        chk(16'(count_q), 16'h0000);
        // A nonzero start timeout sets the success window; delay field 0 waits one rise time.
        ton_max = 24'h00_000C;
        host_u.xfer(1'b1, 1'b0, 8'h41, 16'h00B8, got, rd);
        trip(n);
        chk(16'(n), 16'h0004);
        cyc(10);
        chk(16'(count_q), 16'h0001);
        cyc(4);
        chk(16'(count_q), 16'h0000);
        // A zero retry field latches off at the first trip.
        host_u.xfer(1'b1, 1'b0, 8'h41, 16'h0080, got, rd);
        trip(n);
        chk(16'(n), 16'h00C8);
        enable_req = 1'b0;
        cyc(2);
        enable_req = 1'b1;
        cyc(20);
        // Ignore action keeps running, yet a present fault still blocks a start.
        host_u.xfer(1'b1, 1'b0, 8'h41, 16'h0038, got, rd);
        clr();
        ov_fault_pin = 1'b1;
        cyc(1);
        ov_fault_pin = 1'b0;
        cyc(4);
        chk(16'({power_on_q, f_flag}), 16'h0003);
        enable_req = 1'b0;
        cyc(2);
        chk({5'h00, fault_pct_q}, 16'h044C);
        clr();
        ov_fault_pin = 1'b1;
        cyc(3);
        enable_req = 1'b1;
        cyc(5);
        chk(16'({power_on_q, f_flag}), 16'h0001);
        ov_fault_pin = 1'b0;
        cyc(5);
        chk(16'(power_on_q), 16'h0001);
        clr();
        ov_warn_pin = 1'b1;
        cyc(1);
        ov_warn_pin = 1'b0;
        cyc(3);
        chk(16'({sb_ov, sw_vout, f_flag, w_flag, alert_q}), 16'h000B);
        // Absolute format: the threshold follows the target while the stored word stays put.
        rel_mode = 1'b0;
        host_u.xfer(1'b1, 1'b1, 8'h42, 16'h044C, got, rd);
        cyc(1);
        chk({5'h00, warn_pct_q}, 16'h044C);
        vout_cmd = 16'h041A;
        cyc(2);
        chk({5'h00, warn_pct_q}, 16'h041A);
        host_u.xfer(1'b0, 1'b1, 8'h42, 16'h0000, got, rd);
        chk(rd, 16'h044C);
        // A low clock enable freezes the synchronisers, so a fault pulse then is never seen.
        clr();
        ce = 1'b0;
        ov_fault_pin = 1'b1;
        cyc(4);
        ov_fault_pin = 1'b0;
        ce = 1'b1;
        cyc(4);
        chk(16'({power_on_q, f_flag, alert_q}), 16'h0004);
        finish_test();
    end
endmodule

`default_nettype wire
